// file: common/ovsl_calc_if.sv
// Purpose: Carries the combined target request and the DAC answer
// Assumes: Both ends on mclk
// Notes: Voltages are in 2^-12 V units
`timescale 1ns/10ps
interface ovsl_calc_if;
    import ovsl_pkg::*;
    logic signed [UW-1:0] setpointUnits;
    logic signed [UW-1:0] trimUnits;
    logic [VW-1:0] upperLimit;
    logic [VW-1:0] lowerLimit;
    logic [1:0] scaleSel;
    logic [15:0] slewStep;
    logic [VW-1:0] dacCode;
    logic limitHit;
    logic atTarget;
    modport ctrl (output setpointUnits, trimUnits, upperLimit, lowerLimit, scaleSel, slewStep,
                  input dacCode, limitHit, atTarget);
    modport target (input setpointUnits, trimUnits, upperLimit, lowerLimit, scaleSel, slewStep,
                    output dacCode, limitHit, atTarget);
endinterface

// file: common/ovsl_pkg.sv
// Purpose: Shared constants of the output-voltage setpoint logic
// Assumes: Internal voltage unit is 2^-12 V (exponent -12)
// Notes: Command codes are the bus command bytes of each register
package ovsl_pkg;
    // Command codes of the three registers
    localparam logic [7:0] CMD_FORMAT = 8'h20;
    localparam logic [7:0] CMD_SETPOINT = 8'h21;
    localparam logic [7:0] CMD_TRIM = 8'h22;
    // Output-format byte layout
    localparam int REL_BIT = 7;
    localparam int EXP_MSB = 4;
    localparam logic [1:0] MODE_LINEAR = 2'h0;
    localparam logic [4:0] EXP_COARSE = 5'h1c; // -4
    localparam logic [4:0] EXP_FINE = 5'h14; // -12
    localparam logic [4:0] EXP_RESET = 5'h14;
    localparam logic [7:0] FORMAT_RESET = 8'h14;
    // Trim limits in counts of the current exponent
    localparam logic [15:0] TRIM_MAX = 16'h007f;
    localparam logic [15:0] TRIM_MIN = 16'hff81;
    // Backup trim limit in counts of exponent -12
    localparam logic [7:0] NVM_TRIM_MAX = 8'h7f;
    localparam logic [7:0] NVM_TRIM_MIN = 8'h81;
    // Internal unit width and scale
    localparam int UW = 26;
    localparam int VW = 24;
    localparam int UNITS_PER_V = 4096;
    // Valid setpoint plus trim per loop scale, in millivolts
    localparam int VMAX_MV_S1 = 700;
    localparam int VMAX_MV_S2 = 1400;
    localparam int VMAX_MV_S4 = 2800;
    localparam int VMAX_MV_S8 = 6000;
    localparam logic [VW-1:0] DAC_MAX_S1 = VW'(VMAX_MV_S1 * UNITS_PER_V / 1000);
    localparam logic [VW-1:0] DAC_MAX_S2 = VW'(VMAX_MV_S2 * UNITS_PER_V / 1000);
    localparam logic [VW-1:0] DAC_MAX_S4 = VW'(VMAX_MV_S4 * UNITS_PER_V / 1000);
    localparam logic [VW-1:0] DAC_MAX_S8 = VW'(VMAX_MV_S8 * UNITS_PER_V / 1000);
    // Loop scale selector codes: 1.0, 0.5, 0.25, 0.125
    localparam logic [1:0] SCALE_1 = 2'h0;
    localparam logic [1:0] SCALE_2 = 2'h1;
    localparam logic [1:0] SCALE_4 = 2'h2;
endpackage

// file: testbench/ovsl_host_model.sv
// Purpose: Bus-engine side model that issues one command request at a time
// Assumes: Requests are one-cycle strobes; the answer stands just after the edge that takes them
// Notes: Write data is inverted while idle, so stale data never passes for fresh
`timescale 1ns/10ps
module ovsl_host_model (
    // Clock
    input wire logic mclk,
    // Request side
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdWdata,
    // Answer side
    input wire logic cmdAck,
    input wire logic cmdNack,
    input wire logic [15:0] cmdRdata
);
    // Idle levels at time zero
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdWdata = 16'h0000;
    end

    // Strobe for one cycle, then take the answer once the taking edge has landed
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic nack, output logic [15:0] rdata);
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdCode <= code;
        cmdWdata <= data;
        @(posedge mclk);
        cmdValid <= 1'b0;
        cmdWdata <= ~data;
        #1;
        ack = cmdAck;
        nack = cmdNack;
        rdata = cmdRdata;
    endtask
endmodule // ovsl_host_model

// file: testbench/test_output_voltage_setpoint_logic.sv
// Purpose: Self-checking bench of the setpoint, trim and format logic
// Assumes: Boot format is exponent -12, so counts equal internal units
// Notes: Slew step is large except where the slew itself is watched
`timescale 1ns/10ps
module test_output_voltage_setpoint_logic;
    import ovsl_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, cmdValid, cmdWrite, cmdAck, cmdNack, a, n;
    logic [7:0] cmdCode, trimBackup, nvmFormat = 8'h14;
    logic [15:0] cmdWdata, cmdRdata, r, strapSetpoint = 16'h0600, nvmSetpoint = 16'h0800, slewStep = 16'h7fff;
    logic strapOverride = 1'b0, restoreAll = 1'b0, pgResetPin_n = 1'b1, pgResetEnable = 1'b0;
    logic faultShutdown = 1'b0, faultReloadSelect = 1'b0, clearStatus = 1'b0, dacSettled;
    logic limitClampWarning, statusWordVout, invalidData, hostAlert;
    logic [VW-1:0] upperLimit = 24'h007000, lowerLimit = 24'h000000, dacCode;
    logic [1:0] loopScaleSel = 2'h3;
    logic [23:0] dacMax [4] = '{24'h000b33, 24'h001666, 24'h002ccc, 24'h006000};
    logic [15:0] trimVal [4] = '{16'h007f, 16'h0080, 16'hff81, 16'hff80};
    int errCount = 0, comparisons = 0;

    ovsl_host_model host (.mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdWdata(cmdWdata), .cmdAck(cmdAck), .cmdNack(cmdNack), .cmdRdata(cmdRdata));
    ovsl_setpoint DUT (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdWdata(cmdWdata), .cmdAck(cmdAck), .cmdNack(cmdNack), .cmdRdata(cmdRdata),
        .strapOverride(strapOverride), .strapSetpoint(strapSetpoint), .nvmSetpoint(nvmSetpoint),
        .nvmFormat(nvmFormat), .restoreAll(restoreAll), .pgResetPin_n(pgResetPin_n),
        .pgResetEnable(pgResetEnable), .faultShutdown(faultShutdown), .faultReloadSelect(faultReloadSelect),
        .upperLimit(upperLimit), .lowerLimit(lowerLimit), .loopScaleSel(loopScaleSel), .slewStep(slewStep),
        .clearStatus(clearStatus), .limitClampWarning(limitClampWarning), .statusWordVout(statusWordVout),
        .invalidData(invalidData), .hostAlert(hostAlert), .dacCode(dacCode), .dacSettled(dacSettled),
        .trimBackup(trimBackup));

    // 40 MHz clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Case equality, so an unknown never matches
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic ok);
        host.xfer(1'b1, code, data, a, n, r);
        chk("write ack", {23'h0, ok}, {23'h0, a});
        chk("write nack", {23'h0, !ok}, {23'h0, n});
    endtask

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        host.xfer(1'b0, code, 16'h0000, a, n, r);
        chk("read ack", 24'h000001, {23'h0, a});
        chk("read data", {8'h00, exp}, {8'h00, r});
    endtask

    // Backup copy is registered from the stored trim, so it lags the write by a clock
    task automatic bkp(input logic [7:0] exp);
        @(posedge mclk);
        #1;
        chk("trim backup", {16'h0, exp}, {16'h0, trimBackup});
    endtask

    // Clear flags once the new goal holds; a lasting clamp must raise them again
    task automatic dac(input logic [23:0] exp, input logic warn);
        int i;
        i = 0;
        repeat (3) @(posedge mclk);
        clearStatus <= 1'b1;
        @(posedge mclk) clearStatus <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        while (dacSettled !== 1'b1 && i < 100) begin
            @(posedge mclk) #1;
            i++;
        end
        chk("dac settled", 24'h000001, {23'h0, dacSettled});
        chk("dac code", exp, dacCode);
        chk("clamp warning", {23'h0, warn}, {23'h0, limitClampWarning});
        chk("status word vout", {23'h0, warn}, {23'h0, statusWordVout});
        chk("host alert", {23'h0, warn}, {23'h0, hostAlert});
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog, well past the few hundred cycles the sequence needs
    initial begin
        #500000;
        errCount++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(CMD_SETPOINT, 16'h0800);
        rd(CMD_FORMAT, 16'h0014);
        rd(CMD_TRIM, 16'h0000);
        host.xfer(1'b0, 8'h30, 16'h0000, a, n, r);
        chk("unmapped answer", 24'h0, {22'h0, a, n});
        // Relative bit writable, mode bits ignored on write
        wr(CMD_FORMAT, 16'h00f4, 1'b1);
        rd(CMD_FORMAT, 16'h0094);
        wr(CMD_FORMAT, 16'h0014, 1'b1);
        // Exponents just outside -12..-4 are refused
        wr(CMD_FORMAT, 16'h0013, 1'b0);
        wr(CMD_FORMAT, 16'h001d, 1'b0);
        @(posedge mclk);
        #1;
        chk("invalid data", 24'h1, {23'h0, invalidData});
        chk("host alert", 24'h1, {23'h0, hostAlert});
        rd(CMD_FORMAT, 16'h0014);
        // Coarse exponent rescales and decodes new writes at -4
        wr(CMD_FORMAT, 16'h001c, 1'b1);
        rd(CMD_SETPOINT, 16'h0008);
        wr(CMD_SETPOINT, 16'h0004, 1'b1);
        wr(CMD_TRIM, 16'h0001, 1'b1);
        bkp(8'h7f);
        wr(CMD_TRIM, 16'hffff, 1'b1);
        bkp(8'h81);
        wr(CMD_TRIM, 16'h0080, 1'b0);
        wr(CMD_TRIM, 16'h0000, 1'b1);
        wr(CMD_FORMAT, 16'h0014, 1'b1);
        rd(CMD_SETPOINT, 16'h0400);
        // Trim range boundaries at -12
        for (int i = 0; i < 4; i++) begin
            wr(CMD_TRIM, trimVal[i], i[0] == 1'b0);
        end
        rd(CMD_TRIM, 16'hff81);
        chk("trim backup", 24'h000081, {16'h0, trimBackup});
        wr(CMD_TRIM, 16'h0010, 1'b1);
        wr(CMD_SETPOINT, 16'h0800, 1'b1);
        dac(24'h000810, 1'b0);
        // A small step must take many cycles to cover 0x100 units
        slewStep <= 16'h0010;
        wr(CMD_SETPOINT, 16'h0900, 1'b1);
        repeat (3) @(posedge mclk);
        #1;
        chk("settled early", 24'h0, {23'h0, dacSettled});
        dac(24'h000910, 1'b0);
        slewStep <= 16'h7fff;
        // Limit clamps with warning
        upperLimit <= 24'h000700;
        dac(24'h000700, 1'b1);
        upperLimit <= 24'h007000;
        lowerLimit <= 24'h000a00;
        dac(24'h000a00, 1'b1);
        lowerLimit <= 24'h000000;
        // Valid range edge, then DAC range per loop scale without warning
        wr(CMD_TRIM, 16'h0000, 1'b1);
        wr(CMD_SETPOINT, 16'h6001, 1'b0);
        wr(CMD_SETPOINT, 16'h6000, 1'b1);
        for (int i = 0; i < 4; i++) begin
            loopScaleSel <= 2'(i);
            dac(dacMax[i], 1'b0);
        end
        // Reset pin ignored unless enabled, then returns the boot value
        wr(CMD_SETPOINT, 16'h0900, 1'b1);
        pgResetPin_n <= 1'b0;
        repeat (10) @(posedge mclk);
        pgResetPin_n <= 1'b1;
        repeat (5) @(posedge mclk);
        rd(CMD_SETPOINT, 16'h0900);
        pgResetEnable <= 1'b1;
        pgResetPin_n <= 1'b0;
        repeat (10) @(posedge mclk);
        pgResetPin_n <= 1'b1;
        repeat (5) @(posedge mclk);
        rd(CMD_SETPOINT, 16'h0800);
        // Fault restart keeps or reloads by select
        wr(CMD_SETPOINT, 16'h0900, 1'b1);
        @(posedge mclk) faultShutdown <= 1'b1;
        @(posedge mclk) faultShutdown <= 1'b0;
        rd(CMD_SETPOINT, 16'h0900);
        faultReloadSelect <= 1'b1;
        @(posedge mclk) faultShutdown <= 1'b1;
        @(posedge mclk) faultShutdown <= 1'b0;
        rd(CMD_SETPOINT, 16'h0800);
        // Restore with override takes the strap value
        strapOverride <= 1'b1;
        @(posedge mclk) restoreAll <= 1'b1;
        @(posedge mclk) restoreAll <= 1'b0;
        rd(CMD_SETPOINT, 16'h0600);
        summarize();
    end
endmodule // test_output_voltage_setpoint_logic

// file: verilog/ovsl_setpoint.sv
// Purpose: Output-format, setpoint and trim registers with boot loading
// Assumes: A bus engine outside decodes commands into one-cycle requests
// Notes: Answers come one clock after the request; DAC code is 2^-12 V units
//
// Functional notes
// RQ1 - Format bit 7 selects absolute when clear, relative when set; writable.
// RQ2 - Format mode bits 6:5 are read-only and always read linear code 00.
// RQ3 - Format bits 4:0 hold a signed exponent; only -4 to -12 accepted.
// RQ4 - A format change converts stored voltage values to the new exponent.
// RQ5 - Written voltages decode with the format in force at write time.
// RQ6 - A setpoint write sets the new target, reached at the slew rate.
// RQ7 - Power-good reset pin, when enabled, reloads boot voltage into setpoint.
// RQ8 - Boot default from memory when override is 0, from strap when 1.
// RQ9 - Boot voltage is kept apart from the current setpoint.
// RQ10 - After fault, keep setpoint if reload select is 0, reload boot if 1.
// RQ11 - Sum beyond upper or lower limit clamps there and raises warning.
// RQ12 - Trim is a signed offset added to the setpoint.
// RQ13 - Trim backup keeps 8 bits at exponent -12, limited to +-127.
// RQ14 - Trim writes beyond +-127 counts are refused and flagged invalid.
// RQ15 - Sum over DAC maximum but under upper limit clamps without warning.
// RQ16 - Valid sum is 0.7, 1.4, 2.8 or 6.0 V by loop scale.
// RQ17 - Setpoint writes outside the valid range are refused and flagged.
// RQ18 - Target is recomputed whenever setpoint, trim or format changes.
`timescale 1ns/10ps
module ovsl_setpoint (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command requests from the bus engine
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWdata,
    output logic cmdAck,
    output logic cmdNack,
    output logic [15:0] cmdRdata,
    // Boot sources
    input wire logic strapOverride,
    input wire logic [15:0] strapSetpoint,
    input wire logic [15:0] nvmSetpoint,
    input wire logic [7:0] nvmFormat,
    input wire logic restoreAll,
    // Reset pin and fault handling
    input wire logic pgResetPin_n,
    input wire logic pgResetEnable,
    input wire logic faultShutdown,
    input wire logic faultReloadSelect,
    // Limits and loop settings
    input wire logic [ovsl_pkg::VW-1:0] upperLimit,
    input wire logic [ovsl_pkg::VW-1:0] lowerLimit,
    input wire logic [1:0] loopScaleSel,
    input wire logic [15:0] slewStep,
    // Status
    input wire logic clearStatus,
    output logic limitClampWarning,
    output logic statusWordVout,
    output logic invalidData,
    output logic hostAlert,
    // Outputs to the analog side and backup memory
    output logic [ovsl_pkg::VW-1:0] dacCode,
    output logic dacSettled,
    output logic [7:0] trimBackup
);
    import ovsl_pkg::*;

    typedef struct packed {
        logic relative_select;
        logic [4:0] expo;
        logic [15:0] setpoint;
        logic [15:0] trim;
        logic [15:0] boot;
        logic bootPend;
        logic [1:0] pgSync;
        logic ack;
        logic nack;
        logic [15:0] rdata;
        logic warn;
        logic wordVout;
        logic invalid;
        logic alert;
        logic [7:0] trimNvm;
    } ovsl_state_t;

    ovsl_state_t s_reg, s_next;
    ovsl_calc_if calc ();

    logic [15:0] defaultSetpoint;
    logic pgAsserted;
    logic signed [UW-1:0] spUnits;
    logic signed [UW-1:0] trUnits;
    logic signed [UW-1:0] wrUnits;
    logic [4:0] newExp;
    logic expOk;
    logic trimOk;
    logic spOk;
    logic isWr;

    // Rescale a stored count from one exponent to another
    function automatic logic [15:0] convExp(input logic [15:0] v, input logic [4:0] oldN,
                                            input logic [4:0] newN, input logic sgn);
        logic signed [5:0] d;
        logic signed [16:0] x;
        logic [15:0] r;
        d = $signed({oldN[4], oldN}) - $signed({newN[4], newN});
        x = $signed({sgn & v[15], v});
        if (d >= 0) begin
            r = 16'(x <<< d[3:0]);
        end else begin
            r = 16'(x >>> 4'(-d));
        end
        return r;
    endfunction

    // Express a count of exponent n in 2^-12 V units
    function automatic logic signed [UW-1:0] toUnits(input logic [15:0] v, input logic [4:0] n,
                                                   input logic sgn);
        logic signed [UW-1:0] x;
        logic [4:0] sh;
        x = $signed({{(UW-16){sgn & v[15]}}, v});
        sh = n - EXP_FINE;
        return x <<< sh[3:0];
    endfunction

    // Boot default source chosen by the override strap
    always_comb begin
        defaultSetpoint = strapOverride ? strapSetpoint : nvmSetpoint; // RQ8
        pgAsserted = pgResetEnable & ~s_reg.pgSync[1];
    end

    // Decode and check the request against the format now in force
    always_comb begin
        isWr = cmdValid & cmdWrite;
        newExp = cmdWdata[EXP_MSB:0];
        expOk = ($signed(newExp) <= $signed(EXP_COARSE)) && ($signed(newExp) >= $signed(EXP_FINE)); // RQ3
        trimOk = ($signed(cmdWdata) <= $signed(TRIM_MAX)) && ($signed(cmdWdata) >= $signed(TRIM_MIN)); // RQ14
        wrUnits = toUnits(cmdWdata, s_reg.expo, 1'b0); // RQ5
        spOk = wrUnits <= $signed({2'h0, DAC_MAX_S8}); // RQ17
        spUnits = toUnits(s_reg.setpoint, s_reg.expo, 1'b0);
        trUnits = toUnits(s_reg.trim, s_reg.expo, 1'b1);
    end

    // Request to the clamp and slew stage, refreshed every cycle
    always_comb begin
        calc.setpointUnits = spUnits; // RQ18
        calc.trimUnits = trUnits; // RQ18
        calc.upperLimit = upperLimit;
        calc.lowerLimit = lowerLimit;
        calc.scaleSel = loopScaleSel; // RQ16
        calc.slewStep = slewStep;
    end

    ovsl_target u_target (
        .mclk(mclk),
        .rst(rst),
        .calc(calc)
    );

    // Next state: boot load, reloads, then bus commands
    always_comb begin
        s_next = s_reg;
        s_next.pgSync = {s_reg.pgSync[0], pgResetPin_n};
        s_next.ack = 1'b0;
        s_next.nack = 1'b0;
        if (s_reg.bootPend) begin
            // Straps are sampled only after reset release
            s_next.bootPend = 1'b0;
            s_next.relative_select = nvmFormat[REL_BIT];
            s_next.expo = nvmFormat[EXP_MSB:0];
            s_next.boot = defaultSetpoint; // RQ8
            s_next.setpoint = defaultSetpoint; // RQ9
            s_next.trim = 16'h0000;
        end else if (restoreAll) begin
            s_next.boot = defaultSetpoint; // RQ8
            s_next.setpoint = defaultSetpoint;
        end else if (pgAsserted) begin
            s_next.setpoint = s_reg.boot; // RQ7
        end else if (faultShutdown && faultReloadSelect) begin
            s_next.setpoint = s_reg.boot; // RQ10
        end else if (cmdValid) begin
            s_next.ack = 1'b1;
            unique case (cmdCode)
                CMD_FORMAT: begin
                    s_next.rdata = {8'h00, s_reg.relative_select, MODE_LINEAR, s_reg.expo}; // RQ2
                    if (isWr && expOk) begin
                        s_next.relative_select = cmdWdata[REL_BIT]; // RQ1
                        s_next.expo = newExp;
                        s_next.setpoint = convExp(s_reg.setpoint, s_reg.expo, newExp, 1'b0); // RQ4
                        s_next.trim = convExp(s_reg.trim, s_reg.expo, newExp, 1'b1); // RQ4
                        s_next.boot = convExp(s_reg.boot, s_reg.expo, newExp, 1'b0); // RQ4
                    end else if (isWr) begin
                        s_next.ack = 1'b0;
                        s_next.nack = 1'b1; // RQ3
                    end
                end
                CMD_SETPOINT: begin
                    s_next.rdata = s_reg.setpoint;
                    if (isWr && spOk) begin
                        s_next.setpoint = cmdWdata; // RQ6
                    end else if (isWr) begin
                        s_next.ack = 1'b0;
                        s_next.nack = 1'b1; // RQ17
                    end
                end
                CMD_TRIM: begin
                    s_next.rdata = s_reg.trim;
                    if (isWr && trimOk) begin
                        s_next.trim = cmdWdata; // RQ12
                    end else if (isWr) begin
                        s_next.ack = 1'b0;
                        s_next.nack = 1'b1; // RQ14
                    end
                end
                default: begin
                    // Other commands belong to other blocks: stay silent
                    s_next.ack = 1'b0;
                end
            endcase
        end
        // Sticky status: a new event wins over a clear in the same cycle
        if (clearStatus) begin
            s_next.warn = 1'b0;
            s_next.wordVout = 1'b0;
            s_next.invalid = 1'b0;
        end
        if (calc.limitHit) begin
            s_next.warn = 1'b1; // RQ11
            s_next.wordVout = 1'b1; // RQ11
        end
        if (s_next.nack) begin
            s_next.invalid = 1'b1; // RQ14
        end
        s_next.alert = s_next.warn | s_next.invalid; // RQ11
        // Backup copy at exponent -12, saturated to 8 bits
        if (trUnits > $signed({{(UW-8){1'b0}}, NVM_TRIM_MAX})) begin
            s_next.trimNvm = NVM_TRIM_MAX; // RQ13
        end else if (trUnits < $signed({{(UW-8){1'b1}}, NVM_TRIM_MIN})) begin
            s_next.trimNvm = NVM_TRIM_MIN; // RQ13
        end else begin
            s_next.trimNvm = trUnits[7:0]; // RQ13
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.expo <= EXP_RESET;
            s_reg.bootPend <= 1'b1;
            s_reg.pgSync <= 2'h3;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign cmdAck = s_reg.ack;
    assign cmdNack = s_reg.nack;
    assign cmdRdata = s_reg.rdata;
    assign limitClampWarning = s_reg.warn;
    assign statusWordVout = s_reg.wordVout;
    assign invalidData = s_reg.invalid;
    assign hostAlert = s_reg.alert;
    assign dacCode = calc.dacCode;
    assign dacSettled = calc.atTarget;
    assign trimBackup = s_reg.trimNvm;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Quiet cycle: nothing of higher priority than a command
    sequence quietCmd;
        !s_reg.bootPend && !restoreAll && !pgAsserted && !(faultShutdown && faultReloadSelect) && cmdValid;
    endsequence
    sequence fmtRead;
        quietCmd and (cmdCode == CMD_FORMAT);
    endsequence
    sequence pgHeld;
        !s_reg.bootPend && !restoreAll && pgAsserted [*2];
    endsequence

    chk_mode_reads_linear: assert property (fmtRead and !(isWr && !expOk) |=> cmdAck // RQ2
        && cmdRdata[6:5] == MODE_LINEAR) else $error("Format mode did not read linear");
    chk_bad_exp_refused: assert property (fmtRead and isWr and !expOk |=> cmdNack && invalidData // RQ3
        && $stable(s_reg.expo)) else $error("Bad exponent accepted");
    chk_rel_written: assert property (fmtRead and isWr and expOk |=> s_reg.relative_select == $past(cmdWdata[7])) // RQ1
        else $error("Relative bit not stored");
    chk_trim_refused: assert property (quietCmd and isWr and cmdCode == CMD_TRIM and !trimOk // RQ14
        |=> cmdNack && !cmdAck && $stable(s_reg.trim)) else $error("Out-of-range trim accepted");
    chk_sp_refused: assert property (quietCmd and isWr and cmdCode == CMD_SETPOINT and !spOk // RQ17
        |=> cmdNack && invalidData) else $error("Invalid setpoint accepted");
    chk_pg_reload: assert property (pgHeld |=> s_reg.setpoint == s_reg.boot) // RQ7
        else $error("Reset pin did not reload boot voltage");
    chk_fault_keep: assert property (!s_reg.bootPend && !restoreAll && !pgAsserted && faultShutdown // RQ10
        && !faultReloadSelect && !cmdValid |=> $stable(s_reg.setpoint)) else $error("Setpoint lost on fault");
    chk_boot_source: assert property (restoreAll && !s_reg.bootPend |=> s_reg.boot == // RQ8
        ($past(strapOverride) ? $past(strapSetpoint) : $past(nvmSetpoint))) else $error("Wrong boot source");
    chk_warn_sticky: assert property (calc.limitHit |=> limitClampWarning && statusWordVout ##1 hostAlert // RQ11
        || calc.limitHit) else $error("Limit warning not raised");
    chk_trim_backup: assert property (##1 $signed(trimBackup) <= $signed(NVM_TRIM_MAX) // RQ13
        && $signed(trimBackup) >= $signed(NVM_TRIM_MIN)) else $error("Trim backup out of range");
endmodule // ovsl_setpoint

// file: verilog/ovsl_target.sv
// Purpose: Clamps setpoint plus trim and slews the reference DAC code
// Assumes: Limits arrive already in 2^-12 V units
// Notes: Recomputed every cycle, so any register change retargets the slew at once
`timescale 1ns/10ps
module ovsl_target (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Target request and answer
    ovsl_calc_if.target calc
);
    import ovsl_pkg::*;

    typedef struct packed {
        logic [VW-1:0] dac;
        logic lim;
        logic done;
    } ovsl_tgt_t;

    ovsl_tgt_t s_reg, s_next;
    logic signed [UW:0] sum;
    logic [VW-1:0] dacMax;
    logic [VW-1:0] goal;
    logic limNow;

    // Ceiling of the DAC for the selected loop scale
    always_comb begin
        unique case (calc.scaleSel)
            SCALE_1: dacMax = DAC_MAX_S1;
            SCALE_2: dacMax = DAC_MAX_S2;
            SCALE_4: dacMax = DAC_MAX_S4;
            default: dacMax = DAC_MAX_S8;
        endcase
    end

    // Clamp order: user limits first, then DAC range which raises no warning
    always_comb begin
        sum = (UW+1)'(calc.setpointUnits) + (UW+1)'(calc.trimUnits); // RQ12
        limNow = 1'b0;
        if (sum > $signed({3'h0, calc.upperLimit})) begin
            goal = calc.upperLimit; // RQ11
            limNow = 1'b1;
        end else if (sum < $signed({3'h0, calc.lowerLimit})) begin
            goal = calc.lowerLimit; // RQ11
            limNow = 1'b1;
        end else begin
            goal = VW'(sum);
        end
        if (goal > dacMax) begin
            goal = dacMax; // RQ15
        end
    end

    // Slew the DAC toward the goal by at most slewStep per clock
    always_comb begin
        s_next = s_reg;
        s_next.lim = limNow;
        if (s_reg.dac + VW'(calc.slewStep) < goal) begin
            s_next.dac = s_reg.dac + VW'(calc.slewStep); // RQ6
        end else if (s_reg.dac > goal + VW'(calc.slewStep)) begin
            s_next.dac = s_reg.dac - VW'(calc.slewStep); // RQ6
        end else begin
            s_next.dac = goal;
        end
        s_next.done = (s_next.dac == goal);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign calc.dacCode = s_reg.dac;
    assign calc.limitHit = s_reg.lim;
    assign calc.atTarget = s_reg.done;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_dac_ceiling: assert property (s_reg.dac <= dacMax || $changed(calc.scaleSel) // RQ15
        || $past(calc.scaleSel) != calc.scaleSel || s_reg.dac > s_next.dac)
        else $error("DAC code above scale ceiling");
    chk_limit_flag: assert property (limNow |=> calc.limitHit) // RQ11
        else $error("Limit clamp not flagged");
    chk_slew_bound: assert property (##1 (s_reg.dac - $past(s_reg.dac) <= VW'($past(calc.slewStep))) // RQ6
        || s_reg.dac < $past(s_reg.dac))
        else $error("DAC rose faster than slew step");
endmodule // ovsl_target
